// *** inc/irg_defs.svh ***
// timing constants and reset values for the initial reset generator
`ifndef IRG_DEFS_SVH
`define IRG_DEFS_SVH

`define IRG_CLK_PERIOD_NS 50
`define IRG_GLITCH_NS 100
`define IRG_OSC_FREQ_HZ 32768
`define IRG_RELEASE_FREQ_HZ 2
`define IRG_KEY_FILT_US 1500
`define IRG_AUTH_MIN_MS 1000
`define IRG_GLITCH_CYC ((`IRG_GLITCH_NS + `IRG_CLK_PERIOD_NS - 1) / `IRG_CLK_PERIOD_NS)
`define IRG_DIV_HALF_OSC (`IRG_OSC_FREQ_HZ / (2 * `IRG_RELEASE_FREQ_HZ))
`define IRG_KEY_FILT_OSC ((`IRG_KEY_FILT_US * `IRG_OSC_FREQ_HZ + 999999) / 1000000)
`define IRG_AUTH_OSC ((`IRG_AUTH_MIN_MS * `IRG_OSC_FREQ_HZ + 999) / 1000)
`define IRG_START_ADDR 16'h0110
`define IRG_RESET_ACTIVE 1'b1

`endif

// *** inc/irg_pkg.sv ***
// types for the initial reset generator
package irg_pkg;
    typedef enum logic [1:0] {
        IRG_KEY_OFF = 2'b00,
        IRG_KEY_01 = 2'b01,
        IRG_KEY_012 = 2'b10,
        IRG_KEY_0123 = 2'b11
    } irg_key_sel_t;

    typedef enum logic [1:0] {
        IRG_K_IDLE = 2'b00,
        IRG_K_FILT = 2'b01,
        IRG_K_AUTH = 2'b10,
        IRG_K_FIRE = 2'b11
    } irg_key_state_t;
endpackage

// *** hw/irg_sync.sv ***
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module irg_sync #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule

// *** hw/irg_top.sv ***
// initial reset generator: reset pin latch, key combination reset, release tick
//
// Overview of operation
// - pin or key combination each fully resets
// - pin high resets, pin low releases
// - latch cleared only in 2 Hz high phase
// - release within 250 ms after pin low
// - pin pulses under 100 ns ignored
// - key select off, two, three, four keys
// - key path noise filtered, 1.5 ms hold
// - filter idle until oscillator starts
// - keys must persist one second before reset
// - fetch starts at address 0110H
`timescale 1ns/1ps
`include "irg_defs.svh"
module irg_top #(
    parameter int DIV_HALF_OSC = `IRG_DIV_HALF_OSC,
    parameter int AUTH_OSC = `IRG_AUTH_OSC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic reset_pin,
    input wire logic key_in_0,
    input wire logic key_in_1,
    input wire logic key_in_2,
    input wire logic key_in_3,
    input wire logic low_speed_osc,
    // key combination option
    input wire irg_pkg::irg_key_sel_t key_sel,
    // internal reset and start
    output logic init_reset,
    output logic cpu_start,
    output logic [15:0] start_addr,
    output logic osc_running
);
    import irg_pkg::*;

    localparam logic [1:0] GLITCH_CYC = 2'(`IRG_GLITCH_CYC);
    localparam logic [15:0] DIV_HALF = 16'(DIV_HALF_OSC - 1);
    localparam logic [7:0] FILT_OSC = 8'(`IRG_KEY_FILT_OSC);
    localparam logic [17:0] AUTH_CNT = 18'(AUTH_OSC);

    logic [5:0] pins_sync;
    logic pin_s;
    logic [3:0] key_s;
    logic osc_s;

    // every pin passes two flops first
    irg_sync #(.WIDTH(6)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in({low_speed_osc, key_in_3, key_in_2, key_in_1, key_in_0, reset_pin}),
        .sync_out(pins_sync)
    );

    assign pin_s = pins_sync[0];
    assign key_s = pins_sync[4:1];
    assign osc_s = pins_sync[5];

    // oscillator edge detect, on the synchronised copy only
    logic osc_prev_reg;
    logic osc_started_reg;
    wire osc_tick = osc_s & ~osc_prev_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            osc_prev_reg <= 1'b0;
            osc_started_reg <= 1'b0;
        end else begin
            osc_prev_reg <= osc_s;
            if (osc_tick) begin
                osc_started_reg <= 1'b1;
            end
        end
    end

    // 2 Hz release tick divided from the oscillator
    logic [15:0] div_cnt_reg;
    logic tick_2hz_reg;
    wire div_wrap = (div_cnt_reg == DIV_HALF);
    wire [15:0] div_cnt_next = div_wrap ? 16'h0000 : div_cnt_reg + 16'h0001;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_cnt_reg <= 16'h0000;
            tick_2hz_reg <= 1'b0;
        end else if (osc_tick) begin
            div_cnt_reg <= div_cnt_next;
            if (div_wrap) begin
                tick_2hz_reg <= ~tick_2hz_reg;
            end
        end
    end

    // glitch reject on the pin: short pulses never set the latch
    logic [1:0] pin_cnt_reg;
    wire pin_valid = (pin_cnt_reg == GLITCH_CYC);
    wire [1:0] pin_cnt_next = !pin_s ? 2'h0 : (pin_valid ? pin_cnt_reg : pin_cnt_reg + 2'h1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_cnt_reg <= 2'h0;
        end else begin
            pin_cnt_reg <= pin_cnt_next;
        end
    end

    // key combination select
    logic combo_hit;
    always_comb begin
        case (key_sel)
            IRG_KEY_OFF: combo_hit = 1'b0;
            IRG_KEY_01: combo_hit = key_s[0] & key_s[1];
            IRG_KEY_012: combo_hit = &key_s[2:0];
            IRG_KEY_0123: combo_hit = &key_s;
            default: combo_hit = 1'b0;
        endcase
    end

    // key path: noise filter then time authorize, both on oscillator cycles
    irg_key_state_t kst_reg;
    irg_key_state_t kst_next;
    logic [17:0] kcnt_reg;
    logic [17:0] kcnt_next;
    wire filt_done = (kcnt_reg >= 18'(FILT_OSC));
    // one edge past the limit, so the hold spans whole oscillator periods
    wire auth_done = (kcnt_reg > AUTH_CNT);

    always_comb begin
        kst_next = kst_reg;
        kcnt_next = kcnt_reg;
        case (kst_reg)
            IRG_K_IDLE: begin
                kcnt_next = 18'h00000;
                // no oscillator yet, so no filtering and no counting
                if (combo_hit && osc_started_reg) begin
                    kst_next = IRG_K_FILT;
                end
            end
            IRG_K_FILT: begin
                if (!combo_hit) begin
                    kst_next = IRG_K_IDLE;
                end else if (filt_done) begin
                    kst_next = IRG_K_AUTH;
                end else if (osc_tick) begin
                    kcnt_next = kcnt_reg + 18'h00001;
                end
            end
            IRG_K_AUTH: begin
                if (!combo_hit) begin
                    kst_next = IRG_K_IDLE;
                end else if (auth_done) begin
                    kst_next = IRG_K_FIRE;
                end else if (osc_tick) begin
                    kcnt_next = kcnt_reg + 18'h00001;
                end
            end
            IRG_K_FIRE: begin
                if (!combo_hit) begin
                    kst_next = IRG_K_IDLE;
                end
            end
            default: begin
                kst_next = IRG_K_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            kst_reg <= IRG_K_IDLE;
            kcnt_reg <= 18'h00000;
        end else begin
            kst_reg <= kst_next;
            kcnt_reg <= kcnt_next;
        end
    end

    wire key_req = (kst_reg == IRG_K_FIRE);

    // set/reset latch: either source sets it, set wins over the release
    logic latch_reg;
    wire latch_set = pin_valid | key_req;
    wire latch_clr = tick_2hz_reg;
    wire latch_next = latch_set ? 1'b1 : (latch_clr ? 1'b0 : latch_reg);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_reg <= `IRG_RESET_ACTIVE;
        end else begin
            latch_reg <= latch_next;
        end
    end

    // registered output: all logic leaves reset on one edge
    logic init_reset_reg;
    logic cpu_start_reg;
    logic [15:0] start_addr_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            init_reset_reg <= `IRG_RESET_ACTIVE;
            cpu_start_reg <= 1'b0;
            start_addr_reg <= `IRG_START_ADDR;
        end else begin
            init_reset_reg <= latch_reg;
            cpu_start_reg <= init_reset_reg & ~latch_reg;
            start_addr_reg <= `IRG_START_ADDR;
        end
    end

    assign init_reset = init_reset_reg;
    assign cpu_start = cpu_start_reg;
    assign start_addr = start_addr_reg;
    assign osc_running = osc_started_reg;
endmodule

// *** tb/irg_top_monitor.sv ***
// port checker for the initial reset generator
`timescale 1ns/1ps
module irg_top_monitor #(
    parameter int DIV_HALF_OSC = 4,
    parameter int AUTH_OSC = 60
) (
    // clock, reset, pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic key_in_0,
    input wire logic key_in_1,
    input wire logic key_in_2,
    input wire logic key_in_3,
    input wire logic low_speed_osc,
    input wire irg_pkg::irg_key_sel_t key_sel,
    // outputs
    input wire logic init_reset,
    input wire logic cpu_start,
    input wire logic [15:0] start_addr,
    input wire logic osc_running
);
    import irg_pkg::*;
    // osc period of the far side model, in clk cycles
    localparam int OSC_CYC = 16;
    localparam int REL_MAX = 2 * DIV_HALF_OSC * OSC_CYC + 40;
    localparam int KEY_MIN = AUTH_OSC * OSC_CYC;
    localparam int KEY_MAX = (52 + AUTH_OSC) * OSC_CYC;
    logic combo;
    bit pin_q;
    int quiet_cnt;
    int held_cnt;
    int pair_age;
    assign combo = key_sel != IRG_KEY_OFF && key_in_0 && key_in_1
        && (key_sel == IRG_KEY_01 || key_in_2) && (key_sel != IRG_KEY_0123 || key_in_3);
    always_ff @(posedge clk) begin
        pin_q <= reset_pin;
        pair_age <= (reset_pin && pin_q) ? 0 : pair_age + 1;
        quiet_cnt <= (!rst_n || reset_pin || combo) ? 0 : quiet_cnt + 1;
        held_cnt <= (!rst_n || !combo) ? 0 : held_cnt + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_pin_req;
        reset_pin [*3];
    endsequence
    sequence s_pulse;
        cpu_start ##1 !cpu_start;
    endsequence
    a_addr_fixed: assert property (start_addr == 16'h0110)
        else $error("start address wrong");
    a_start_pulse: assert property ($fell(init_reset) |-> s_pulse)
        else $error("no start pulse after release");
    a_pin_sets: assert property (s_pin_req |-> ##[1:8] init_reset)
        else $error("pin did not reset");
    a_pin_holds: assert property (reset_pin [*8] |-> init_reset)
        else $error("reset dropped while pin high");
    a_no_stray: assert property ($rose(init_reset) |-> pair_age < 10 || held_cnt >= KEY_MIN)
        else $error("reset without valid request");
    a_release_bound: assert property (quiet_cnt == REL_MAX |-> !init_reset)
        else $error("release too late");
    a_key_fires: assert property (held_cnt == KEY_MAX |-> init_reset)
        else $error("key combination did not reset");
    a_osc_stays: assert property (osc_running |=> osc_running)
        else $error("oscillator flag dropped");
endmodule
bind irg_top irg_top_monitor #(.DIV_HALF_OSC(DIV_HALF_OSC), .AUTH_OSC(AUTH_OSC)) u_mon (
    .clk, .rst_n, .reset_pin, .key_in_0, .key_in_1, .key_in_2, .key_in_3, .low_speed_osc,
    .key_sel, .init_reset, .cpu_start, .start_addr, .osc_running);

// *** tb/irg_far_side.sv ***
// far side model: reset source, key switches, slow oscillator
`timescale 1ns/1ps
module irg_far_side #(
    parameter int OSC_HALF = 8
) (
    input wire logic clk,
    output logic reset_pin,
    output logic [3:0] keys,
    output logic low_speed_osc
);
    int osc_cnt = 0;
    initial begin
        reset_pin = 1'b0;
        keys = 4'h0;
        low_speed_osc = 1'b0;
    end
    // oscillator starts late, as after power-up
    always @(posedge clk) begin
        osc_cnt <= osc_cnt + 1;
        if (osc_cnt >= 20 && osc_cnt % OSC_HALF == 0) begin
            low_speed_osc <= !low_speed_osc;
        end
    end
    // released pins fall to their pull-down level
    task automatic pin_hold(input int n);
        reset_pin <= 1'b1;
        repeat (n) @(posedge clk);
        reset_pin <= 1'b0;
    endtask
    task automatic key_hold(input logic [3:0] k, input int n);
        keys <= k;
        repeat (n) @(posedge clk);
        keys <= 4'h0;
    endtask
endmodule

// *** tb/tb.sv ***
// testbench for the initial reset generator
`timescale 1ns/1ps
module tb;
    import irg_pkg::*;
    localparam int DIV = 4;
    localparam int AUTH = 60;
    localparam int REL = 2 * DIV * 16 + 40;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reset_pin, low_speed_osc, init_reset, cpu_start, osc_running;
    logic [3:0] keys;
    logic [15:0] start_addr;
    irg_key_sel_t key_sel = IRG_KEY_OFF;
    int error_cnt = 0;
    int checked = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    irg_far_side u_far (.clk, .reset_pin, .keys, .low_speed_osc);
    irg_top #(.DIV_HALF_OSC(DIV), .AUTH_OSC(AUTH)) u_irg_top (.clk, .rst_n, .reset_pin,
        .key_in_0(keys[0]), .key_in_1(keys[1]), .key_in_2(keys[2]), .key_in_3(keys[3]),
        .low_speed_osc, .key_sel, .init_reset, .cpu_start, .start_addr, .osc_running);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait, so a stuck reset still ends the test
    task automatic wait_free(output int n);
        n = 0;
        while (init_reset !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_boot();
        int n;
        check(init_reset, 1'b1);
        check(cpu_start, 1'b0);
        check(start_addr, 16'h0110);
        check(osc_running, 1'b0);
        rst_n <= 1'b1;
        wait_free(n);
        check(n <= REL, 1'b1);
        check(osc_running, 1'b1);
        $display("done boot");
    endtask
    task automatic t_pin();
        int n;
        @(posedge clk);
        u_far.pin_hold(2000);
        check(init_reset, 1'b1);
        wait_free(n);
        check(n <= REL, 1'b1);
        check(cpu_start, 1'b1);
        $display("done pin");
    endtask
    task automatic t_glitch();
        @(posedge clk);
        u_far.pin_hold(1);
        repeat (12) @(negedge clk);
        check(init_reset, 1'b0);
        $display("done glitch");
    endtask
    task automatic t_keys();
        int n;
        logic [3:0] need;
        for (int s = 0; s < 4; s++) begin
            need = s == 0 ? 4'hF : (4'h1 << (s + 1)) - 4'h1;
            @(posedge clk);
            key_sel <= irg_key_sel_t'(s);
            u_far.key_hold(need >> 1, 1900);
            check(init_reset, 1'b0);
            @(posedge clk);
            u_far.key_hold(need, 1900);
            check(init_reset, s != 0);
            wait_free(n);
            check(n <= REL, 1'b1);
        end
        @(posedge clk);
        u_far.key_hold(4'hF, AUTH * 16);
        repeat (12) @(negedge clk);
        check(init_reset, 1'b0);
        $display("done keys");
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        t_boot();
        t_pin();
        t_glitch();
        t_keys();
        stop_test();
    end
endmodule
